// ===== inc/src_pkg.sv
package src_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_KHZ = 25000;
	localparam int SETTLE_US = 15000;
	localparam int SETTLE_CYC = SETTLE_US * CLK_KHZ / 1000;
	localparam int BO_HOLD_US = 500;
	localparam int BO_HOLD_CYC = BO_HOLD_US * CLK_KHZ / 1000;
	localparam int BOOT_DIV = 2;
	localparam int HOLD_TICKS = 8;
	localparam int CNT_W = 20;
	// ==========================================================
	// Register offsets
	localparam logic [11:0] ADDR_IDENT0 = 12'h000;
	localparam logic [11:0] ADDR_IDENT1 = 12'h004;
	localparam logic [11:0] ADDR_CAP0 = 12'h008;
	localparam logic [11:0] ADDR_CAP1 = 12'h010;
	localparam logic [11:0] ADDR_CAP2 = 12'h014;
	localparam logic [11:0] ADDR_CAP3 = 12'h018;
	localparam logic [11:0] ADDR_CAP4 = 12'h01c;
	localparam logic [11:0] ADDR_BOCTL = 12'h030;
	localparam logic [11:0] ADDR_LDOCTL = 12'h034;
	localparam logic [11:0] ADDR_SOFT0 = 12'h040;
	localparam logic [11:0] ADDR_SOFT1 = 12'h044;
	localparam logic [11:0] ADDR_SOFT2 = 12'h048;
	localparam logic [11:0] ADDR_CAUSE = 12'h05c;
	localparam logic [11:0] ADDR_WDLOAD = 12'h100;
	localparam logic [11:0] ADDR_WDCTL = 12'h104;
	localparam logic [11:0] ADDR_WDVAL = 12'h108;
	localparam logic [11:0] ADDR_WDICLR = 12'h10c;
	// ==========================================================
	// Reset values
	localparam logic [31:0] CAP0_RST = 32'h00070003;
	localparam logic [31:0] CAP1_RST = 32'h0000901f;
	localparam logic [31:0] CAP2_RST = 32'h03030011;
	localparam logic [31:0] CAP3_RST = 32'h00000000;
	localparam logic [31:0] CAP4_RST = 32'h00000000;
	localparam logic [31:0] WDLOAD_RST = 32'hffffffff;
	localparam logic [5:0] CAUSE_RST = 6'h02;
	// ==========================================================
	// Field positions
	localparam int CAUSE_EXT = 0;
	localparam int CAUSE_POR = 1;
	localparam int CAUSE_BOR = 2;
	localparam int CAUSE_WDT = 3;
	localparam int CAUSE_SW = 4;
	localparam int CAUSE_LDO = 5;
	localparam int BO_WAIT = 0;
	localparam int BO_RSEL = 1;
	localparam int BO_EN = 2;
	localparam int BO_DLY_LSB = 8;
	localparam int BO_DLY_W = 16;
	localparam int WD_EN = 0;
	localparam int WD_RESEN = 1;
	// ==========================================================
	// Encodings
	localparam logic [1:0] STAGE_IDLE = 2'h0;
	localparam logic [1:0] STAGE_SP = 2'h1;
	localparam logic [1:0] STAGE_PC = 2'h2;
	localparam logic [1:0] STAGE_INSN = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		SEQ_PINHOLD, SEQ_SETTLE, SEQ_HOLD, SEQ_FETCH_SP,
		SEQ_FETCH_PC, SEQ_FETCH_INSN, SEQ_RUN
	} src_state_t;
endpackage : src_pkg

// ===== rtl/src_sync3.sv
module src_sync3 #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	import src_pkg::*;
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	generate
		if (W < 1) begin : g_bad
			$error("src_sync3: W must be at least 1");
		end
	endgenerate
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			// Change accepted once stages two and three agree
			dout <= (s2 & s3) | (dout & (s2 | s3));
		end
	end
endmodule : src_sync3

// ===== rtl/src_wdog.sv
module src_wdog (
	input wire logic clock,
	input wire logic rstn,
	input wire logic clear,
	input wire logic enable,
	input wire logic reset_en,
	input wire logic [31:0] load,
	input wire logic load_wr,
	input wire logic int_clr,
	output logic irq,
	output logic rst_pulse,
	output logic [31:0] count
);
	import src_pkg::*;
	wire logic zero = (count == 32'h0);
	wire logic expire = enable && zero;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count <= WDLOAD_RST;
			irq <= 1'b0;
			rst_pulse <= 1'b0;
		end else if (clear) begin
			count <= load;
			irq <= 1'b0;
			rst_pulse <= 1'b0;
		end else begin
			// First zero interrupts, second resets if still pending
			rst_pulse <= expire && irq && reset_en;
			if (expire || load_wr) begin
				count <= load;
			end else if (enable) begin
				count <= count - 32'h1;
			end
			if (expire) begin
				irq <= 1'b1;
			end else if (int_clr) begin
				irq <= 1'b0;
			end
		end
	end
endmodule : src_wdog

// ===== rtl/src_top.sv
module src_top
	import src_pkg::*;
#(
	parameter int SETTLE_CYCLES = src_pkg::SETTLE_CYC,
	parameter int BO_HOLD_CYCLES = src_pkg::BO_HOLD_CYC,
	parameter logic [31:0] IDENT0 = 32'h00a5_0001, // Arbitrary value
	parameter logic [31:0] IDENT1 = 32'h005a_0002 // Arbitrary value
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rst_pin_n,
	input wire logic por_det,
	input wire logic brownout_detect,
	input wire logic ldo_unreg,
	input wire logic system_reset_request,
	output logic sys_rst_n,
	output logic tap_rst_n,
	output logic [95:0] periph_rst_run,
	output logic [95:0] periph_rst_sleep,
	output logic [1:0] boot_stage,
	output logic core_run,
	output logic brownout_irq,
	output logic watchdog_irq
);
	import src_pkg::*;
	generate
		if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= 2 ** CNT_W ||
			BO_HOLD_CYCLES < 1 || BO_HOLD_CYCLES >= 2 ** CNT_W) begin : g_bad
			$error("src_top: cycle count out of range");
		end
	endgenerate

	function automatic logic [31:0] src_merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (old & ~m) | (d & m);
	endfunction : src_merge

	// ==========================================================
	// Pin synchronisers
	logic [3:0] sync_out;
	src_sync3 #(.W(4)) u_sync (
		.clock(clock),
		.rstn(rstn),
		.din({ldo_unreg, brownout_detect, por_det, ~rst_pin_n}),
		.dout(sync_out)
	);
	wire logic pin_s = sync_out[0];
	wire logic por_s = sync_out[1];
	wire logic bo_s = sync_out[2];
	wire logic ldo_s = sync_out[3];

	// ==========================================================
	// Registers and bus state
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [31:0] bo_ctl;
	logic ldo_en;
	logic [31:0] soft0;
	logic [31:0] soft1;
	logic [31:0] soft2;
	logic [31:0] wd_load;
	logic [1:0] wd_ctl;
	logic [5:0] cause;
	logic [31:0] wd_count;
	logic wd_rst;
	wire logic [11:0] wa = aw_addr_q[11:0];
	wire logic wr_go = !awready && !wready && !bvalid;
	wire logic wr_boctl = wr_go && wa == ADDR_BOCTL;
	wire logic wr_ldo = wr_go && wa == ADDR_LDOCTL;
	wire logic wr_soft0 = wr_go && wa == ADDR_SOFT0;
	wire logic wr_soft1 = wr_go && wa == ADDR_SOFT1;
	wire logic wr_soft2 = wr_go && wa == ADDR_SOFT2;
	wire logic wr_cause = wr_go && wa == ADDR_CAUSE;
	wire logic wr_wdload = wr_go && wa == ADDR_WDLOAD;
	wire logic wr_wdctl = wr_go && wa == ADDR_WDCTL;
	wire logic wr_wdiclr = wr_go && wa == ADDR_WDICLR;
	wire logic wr_ro = wa == ADDR_IDENT0 || wa == ADDR_IDENT1 ||
		wa == ADDR_CAP0 || wa == ADDR_CAP1 || wa == ADDR_CAP2 ||
		wa == ADDR_CAP3 || wa == ADDR_CAP4 || wa == ADDR_WDVAL;
	wire logic wr_hit = wr_ro || wr_boctl || wr_ldo || wr_soft0 ||
		wr_soft1 || wr_soft2 || wr_cause || wr_wdload || wr_wdctl ||
		wr_wdiclr;
	wire logic [31:0] wmask = src_merge(32'h0, w_data_q, w_strb_q);
	// Reload value seen by the watchdog in the cycle of a load write
	wire logic [31:0] wd_load_new = wr_wdload ?
		src_merge(wd_load, w_data_q, w_strb_q) : wd_load;
	// Read data for identification, capability, control and status registers
	wire logic [31:0] rd_val =
		araddr == ADDR_IDENT0 ? IDENT0 :
		araddr == ADDR_IDENT1 ? IDENT1 :
		araddr == ADDR_CAP0 ? CAP0_RST :
		araddr == ADDR_CAP1 ? CAP1_RST :
		araddr == ADDR_CAP2 ? CAP2_RST :
		araddr == ADDR_CAP3 ? CAP3_RST :
		araddr == ADDR_CAP4 ? CAP4_RST :
		araddr == ADDR_BOCTL ? bo_ctl :
		araddr == ADDR_LDOCTL ? {31'h0, ldo_en} :
		araddr == ADDR_SOFT0 ? soft0 :
		araddr == ADDR_SOFT1 ? soft1 :
		araddr == ADDR_SOFT2 ? soft2 :
		araddr == ADDR_CAUSE ? {26'h0, cause} :
		araddr == ADDR_WDLOAD ? wd_load :
		araddr == ADDR_WDCTL ? {30'h0, wd_ctl} :
		araddr == ADDR_WDVAL ? wd_count : 32'h0;
	wire logic rd_hit = araddr == ADDR_IDENT0 || araddr == ADDR_IDENT1 ||
		araddr == ADDR_CAP0 || araddr == ADDR_CAP1 ||
		araddr == ADDR_CAP2 || araddr == ADDR_CAP3 ||
		araddr == ADDR_CAP4 || araddr == ADDR_BOCTL ||
		araddr == ADDR_LDOCTL || araddr == ADDR_SOFT0 ||
		araddr == ADDR_SOFT1 || araddr == ADDR_SOFT2 ||
		araddr == ADDR_CAUSE || araddr == ADDR_WDLOAD ||
		araddr == ADDR_WDCTL || araddr == ADDR_WDVAL ||
		araddr == ADDR_WDICLR;

	// ==========================================================
	// AXI4-Lite slave
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			aw_addr_q <= 32'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_addr_q <= {20'h0, awaddr};
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				wready <= 1'b0;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				awready <= 1'b1;
				wready <= 1'b1;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_val;
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bo_ctl <= 32'h0;
			ldo_en <= 1'b0;
			soft0 <= 32'h0;
			soft1 <= 32'h0;
			soft2 <= 32'h0;
			wd_load <= WDLOAD_RST;
			wd_ctl <= 2'h0;
		end else begin
			if (wr_boctl) bo_ctl <= src_merge(bo_ctl, w_data_q, w_strb_q);
			if (wr_ldo) ldo_en <= wmask[0];
			if (wr_soft0) soft0 <= src_merge(soft0, w_data_q, w_strb_q);
			if (wr_soft1) soft1 <= src_merge(soft1, w_data_q, w_strb_q);
			if (wr_soft2) soft2 <= src_merge(soft2, w_data_q, w_strb_q);
			if (wr_wdload) wd_load <= src_merge(wd_load, w_data_q, w_strb_q);
			if (wr_wdctl) wd_ctl <= wmask[1:0];
		end
	end

	// ==========================================================
	// Watchdog
	src_wdog u_wdog (
		.clock(clock),
		.rstn(rstn),
		.clear(!sys_rst_n),
		.enable(wd_ctl[WD_EN]),
		.reset_en(wd_ctl[WD_RESEN]),
		.load(wd_load_new),
		.load_wr(wr_wdload),
		.int_clr(wr_wdiclr),
		.irq(watchdog_irq),
		.rst_pulse(wd_rst),
		.count(wd_count)
	);

	// ==========================================================
	// Brownout filter and hold
	logic bo_prev;
	logic [BO_DLY_W-1:0] bo_wait;
	logic [CNT_W-1:0] bo_hold;
	wire logic [BO_DLY_W-1:0] bo_dly = bo_ctl[BO_DLY_LSB +: BO_DLY_W];
	wire logic bo_start = bo_ctl[BO_EN] && bo_s && !bo_prev &&
		bo_hold == '0 && bo_wait == '0;
	wire logic bo_act = bo_ctl[BO_EN] && bo_hold == '0 &&
		(bo_ctl[BO_WAIT] ? (bo_wait == 16'h1 && bo_s) : bo_start);
	wire logic bo_rst = bo_act && bo_ctl[BO_RSEL];
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bo_prev <= 1'b0;
			bo_wait <= '0;
			bo_hold <= '0;
			brownout_irq <= 1'b0;
		end else begin
			bo_prev <= bo_s;
			brownout_irq <= bo_act && !bo_ctl[BO_RSEL];
			if (bo_wait != '0) begin
				bo_wait <= bo_wait - 16'h1;
			end else if (bo_start && bo_ctl[BO_WAIT]) begin
				bo_wait <= bo_dly == '0 ? 16'h1 : bo_dly;
			end
			if (bo_rst) begin
				bo_hold <= CNT_W'(BO_HOLD_CYCLES);
			end else if (bo_hold != '0) begin
				bo_hold <= bo_hold - 20'h1;
			end
		end
	end

	// ==========================================================
	// Reset sequencer
	src_state_t state;
	src_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic por_done;
	logic [3:0] div;
	logic boot_tick;
	wire logic pin_req = pin_s;
	wire logic por_req = por_s && !por_done;
	wire logic sw_req = system_reset_request;
	wire logic ldo_req = ldo_en && ldo_s;
	wire logic int_req = bo_rst || wd_rst || sw_req || ldo_req;
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		if (pin_req || por_req) begin
			next_state = SEQ_PINHOLD;
			next_cnt = '0;
		end else begin
			case (state)
				SEQ_PINHOLD: begin
					next_state = SEQ_SETTLE;
					next_cnt = '0;
				end
				SEQ_SETTLE: begin
					// Main clock counts the settle time
					if (cnt == CNT_W'(SETTLE_CYCLES - 1)) begin
						next_state = SEQ_FETCH_SP;
					end else begin
						next_cnt = cnt + 20'h1;
					end
				end
				SEQ_HOLD: begin
					if (boot_tick && cnt == CNT_W'(HOLD_TICKS - 1)) begin
						next_state = SEQ_FETCH_SP;
					end else if (boot_tick) begin
						next_cnt = cnt + 20'h1;
					end
				end
				SEQ_FETCH_SP: next_state = SEQ_FETCH_PC;
				SEQ_FETCH_PC: next_state = SEQ_FETCH_INSN;
				SEQ_FETCH_INSN: next_state = SEQ_RUN;
				SEQ_RUN: begin
					if (int_req) begin
						next_state = SEQ_HOLD;
						next_cnt = '0;
					end
				end
				default: next_state = SEQ_PINHOLD;
			endcase
		end
	end
	wire logic next_rel = next_state inside {SEQ_FETCH_SP, SEQ_FETCH_PC,
		SEQ_FETCH_INSN, SEQ_RUN};
	wire logic [1:0] next_stage =
		next_state == SEQ_FETCH_SP ? STAGE_SP :
		next_state == SEQ_FETCH_PC ? STAGE_PC :
		next_state == SEQ_FETCH_INSN ? STAGE_INSN : STAGE_IDLE;
	wire logic [95:0] soft_all = {soft2, soft1, soft0};
	wire logic [5:0] cause_set = {6{state == SEQ_RUN}} &
		{ldo_req, sw_req, wd_rst, bo_rst, 2'b00};
	wire logic [5:0] cause_clr = wr_cause ? wmask[5:0] : 6'h0;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= SEQ_PINHOLD;
			cnt <= '0;
			por_done <= 1'b0;
			div <= 4'h0;
			boot_tick <= 1'b0;
			sys_rst_n <= 1'b0;
			tap_rst_n <= 1'b0;
			periph_rst_run <= '1;
			periph_rst_sleep <= '1;
			boot_stage <= STAGE_IDLE;
			core_run <= 1'b0;
			cause <= CAUSE_RST;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			div <= div == 4'(BOOT_DIV - 1) ? 4'h0 : div + 4'h1;
			boot_tick <= div == 4'(BOOT_DIV - 1);
			// Armed only once the first settle completes, not on sync lag
			if (state == SEQ_SETTLE && next_rel) por_done <= 1'b1;
			sys_rst_n <= next_rel;
			tap_rst_n <= !por_req;
			periph_rst_run <= soft_all | {96{!next_rel}};
			periph_rst_sleep <= soft_all | {96{!next_rel}};
			boot_stage <= next_stage;
			core_run <= next_state == SEQ_RUN;
			if (pin_req) begin
				cause <= 6'(1 << CAUSE_EXT) |
					(por_req ? 6'(1 << CAUSE_POR) : 6'h0);
			end else begin
				cause <= (cause & ~cause_clr) | cause_set |
					(por_req ? 6'(1 << CAUSE_POR) : 6'h0);
			end
		end
	end

	// ==========================================================
	// Checks
	logic [CNT_W-1:0] settle_run;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) settle_run <= '0;
		else if (state == SEQ_SETTLE) settle_run <= settle_run + 20'h1;
		else if (state == SEQ_PINHOLD) settle_run <= '0;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	a_pin_holds_reset: assert property (pin_req |=> !sys_rst_n && tap_rst_n == !$past(por_req))
		else $error("pin reset did not hold system reset");
	a_settle_min_time: assert property ((state == SEQ_FETCH_SP && $past(state) == SEQ_SETTLE) |-> settle_run == CNT_W'(SETTLE_CYCLES))
		else $error("settle time wrong");
	a_release_waits: assert property ((pin_req || por_req) |=> !sys_rst_n ##1 !sys_rst_n)
		else $error("released while pin or power-on active");
	a_fetch_order: assert property ($rose(sys_rst_n) |-> boot_stage == STAGE_SP ##1 (boot_stage == STAGE_PC || !sys_rst_n))
		else $error("fetch order broken");
	a_ext_clears_cause: assert property ((pin_req && !por_req) |=> cause == 6'h01)
		else $error("pin reset left other cause bits");
	a_por_only_once: assert property ((por_done && !pin_req) |=> state != SEQ_PINHOLD)
		else $error("power-on reset retriggered");
	a_bo_disabled: assert property (!bo_ctl[BO_EN] |=> !brownout_irq && state != SEQ_HOLD || $past(int_req) || $past(state) == SEQ_HOLD)
		else $error("brownout acted while disabled");
	a_bo_select: assert property (bo_act && !bo_ctl[BO_RSEL] |=> brownout_irq && $stable(bo_hold))
		else $error("brownout reset without select");
	a_bo_resample: assert property ((bo_ctl[BO_WAIT] && bo_wait == 16'h1 && !bo_s) |=> !brownout_irq && bo_wait == '0)
		else $error("brownout acted on absent resample");
	a_bo_hold_time: assert property (bo_rst |=> bo_hold == CNT_W'(BO_HOLD_CYCLES) ##1 !bo_act)
		else $error("brownout hold wrong");
	a_soft_rst_lanes: assert property ((wr_soft1 && w_strb_q[0] && w_data_q[0]) |-> ##2 (periph_rst_run[32] && periph_rst_sleep[32]))
		else $error("soft reset not applied");
	a_sysreq_reset: assert property ((core_run && system_reset_request && !pin_req && !por_req) |=> !sys_rst_n && cause[CAUSE_SW])
		else $error("system reset request ignored");
	a_wdog_second: assert property (wd_rst |-> $past(watchdog_irq) && $past(wd_ctl[WD_RESEN]))
		else $error("watchdog reset without pending interrupt");
	a_ldo_reset: assert property ((core_run && ldo_req && !pin_req && !por_req) |=> !sys_rst_n && cause[CAUSE_LDO])
		else $error("drop-out reset ignored");
	c_release: cover property ($rose(sys_rst_n));
	c_bo_reset: cover property (bo_rst);
	c_wd_reset: cover property (wd_rst);
	c_bo_filtered: cover property (bo_ctl[BO_WAIT] && bo_wait == 16'h1 && !bo_s);
endmodule : src_top

// ===== tb/src_core_model.sv
module src_core_model
	import src_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic sys_rst_n,
	input wire logic [1:0] boot_stage,
	input wire logic core_run,
	input wire logic go,
	output logic system_reset_request,
	output int boots,
	output int order_err
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] last;
	logic run_q;
	// ==========================================================
	// Fetch order watch and reset request
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			last <= STAGE_IDLE;
			run_q <= 1'b0;
			boots <= 0;
			order_err <= 0;
			system_reset_request <= 1'b0;
		end else begin
			last <= boot_stage;
			run_q <= core_run;
			if (boot_stage != STAGE_IDLE && boot_stage != last + 2'h1)
				order_err <= order_err + 1;
			if (core_run && !run_q && last != STAGE_INSN)
				order_err <= order_err + 1;
			if (core_run && !run_q)
				boots <= boots + 1;
			// Only running code can ask
			system_reset_request <= go && core_run && sys_rst_n;
		end
	end
endmodule : src_core_model

// ===== tb/system_reset_controller_test.sv
module system_reset_controller_test
	import src_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ST = 20;
	logic clock, rstn, awvalid, wvalid, bready, arvalid, rready, go;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic rst_pin_n, por_det, brownout_detect, ldo_unreg, rq;
	logic awready, wready, bvalid, arready, rvalid, sys_rst_n, tap_rst_n;
	logic [1:0] bresp, rresp, boot_stage;
	logic [95:0] prun, psl;
	logic core_run, brownout_irq, watchdog_irq, bo_seen, rst_seen;
	int fail_count, cmp_count, boots, order_err, n;

	src_top #(.SETTLE_CYCLES(ST), .BO_HOLD_CYCLES(10)) u_src_top (
		.clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.rst_pin_n(rst_pin_n), .por_det(por_det),
		.brownout_detect(brownout_detect), .ldo_unreg(ldo_unreg),
		.system_reset_request(rq), .sys_rst_n(sys_rst_n),
		.tap_rst_n(tap_rst_n), .periph_rst_run(prun),
		.periph_rst_sleep(psl), .boot_stage(boot_stage),
		.core_run(core_run), .brownout_irq(brownout_irq),
		.watchdog_irq(watchdog_irq));

	src_core_model u_src_core_model (
		.clock(clock), .rstn(rstn), .sys_rst_n(sys_rst_n),
		.boot_stage(boot_stage), .core_run(core_run), .go(go),
		.system_reset_request(rq), .boots(boots), .order_err(order_err));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(posedge clock) begin
		if (brownout_irq === 1'b1) bo_seen <= 1'b1;
		if (sys_rst_n === 1'b0) rst_seen <= 1'b1;
	end

	// ==========================================================
	// Checking and bus tasks
	task automatic chk(input string nm, input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task automatic finish_test;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic tmo(input int k);
		if (k >= 2000) begin
			chk("timeout", 0, 1);
			finish_test();
		end
	endtask : tmo

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int k;
		k = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			k++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && k < 2000);
		bready <= 1'b0;
		tmo(k);
		chk("bresp", bresp, e);
	endtask : wr

	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [31:0] e, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			k++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && k < 2000);
		rready <= 1'b0;
		tmo(k);
		chk(nm, rdata, e);
		chk(nm, rresp, er);
	endtask : rdc

	task automatic wait_run(output int k);
		k = 0;
		while (sys_rst_n !== 1'b0 && k < 2000) begin
			@(posedge clock);
			k++;
		end
		tmo(k);
		k = 0;
		while (core_run !== 1'b1 && k < 2000) begin
			@(posedge clock);
			k++;
		end
		tmo(k);
	endtask : wait_run

	task automatic bo_pulse;
		@(posedge clock);
		rst_seen <= 1'b0;
		bo_seen <= 1'b0;
		brownout_detect <= 1'b1;
		repeat (4) @(posedge clock);
		brownout_detect <= 1'b0;
		repeat (44) @(posedge clock);
	endtask : bo_pulse

	// ==========================================================
	// Main sequence
	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
		{awaddr, araddr, wdata, brownout_detect, ldo_unreg} = '0;
		{rst_pin_n, por_det, fail_count, cmp_count} = '0;
		{bo_seen, rst_seen} = '0;
		rst_pin_n = 1'b1;
		por_det = 1'b1;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		repeat (30) @(posedge clock);
		chk("por hold", sys_rst_n, 0);
		por_det <= 1'b0;
		wait_run(n);
		chk("por settle", n > ST, 1);
		chk("tap por", tap_rst_n, 1);
		rdc("cause", ADDR_CAUSE, 32'h02, RESP_OKAY);
		rdc("cap0", ADDR_CAP0, CAP0_RST, RESP_OKAY);
		rdc("cap1", ADDR_CAP1, CAP1_RST, RESP_OKAY);
		rdc("cap2", ADDR_CAP2, CAP2_RST, RESP_OKAY);
		wr(ADDR_CAP0, 32'h0, RESP_OKAY);
		rdc("cap0 ro", ADDR_CAP0, CAP0_RST, RESP_OKAY);
		rdc("unmapped", 12'hffc, 32'h0, RESP_SLVERR);
		wr(12'hffc, 32'h1, RESP_SLVERR);
		$display("test power-up done");
		rst_pin_n <= 1'b0;
		repeat (10) @(posedge clock);
		chk("pin rst", sys_rst_n, 0);
		chk("pin tap", tap_rst_n, 1);
		chk("pin periph", prun[95:64], 32'hffffffff);
		rst_pin_n <= 1'b1;
		wait_run(n);
		chk("pin settle", n > ST, 1);
		rdc("cause", ADDR_CAUSE, 32'h01, RESP_OKAY);
		$display("test pin done");
		wr(ADDR_SOFT1, 32'h5, RESP_OKAY);
		repeat (2) @(posedge clock);
		chk("soft run", prun[63:32], 32'h5);
		chk("soft sleep", psl[63:32], 32'h5);
		chk("soft sys", sys_rst_n, 1);
		wr(ADDR_SOFT1, 32'h0, RESP_OKAY);
		repeat (2) @(posedge clock);
		chk("soft off", prun[63:32], 32'h0);
		$display("test soft done");
		rst_seen <= 1'b0;
		go <= 1'b1;
		repeat (2) @(posedge clock);
		go <= 1'b0;
		wait_run(n);
		chk("sw rst", rst_seen, 1);
		rdc("cause", ADDR_CAUSE, 32'h11, RESP_OKAY);
		bo_pulse();
		chk("bo off irq", bo_seen, 0);
		chk("bo off rst", rst_seen, 0);
		wr(ADDR_BOCTL, 32'h4, RESP_OKAY);
		bo_pulse();
		chk("bo irq", bo_seen, 1);
		chk("bo no rst", rst_seen, 0);
		wr(ADDR_BOCTL, 32'h6, RESP_OKAY);
		bo_pulse();
		chk("bo rst", rst_seen, 1);
		chk("bo run", core_run, 1);
		rdc("cause", ADDR_CAUSE, 32'h15, RESP_OKAY);
		wr(ADDR_BOCTL, 32'h2007, RESP_OKAY);
		bo_pulse();
		chk("bo glitch", rst_seen, 0);
		$display("test brownout done");
		wr(ADDR_LDOCTL, 32'h1, RESP_OKAY);
		rst_seen <= 1'b0;
		ldo_unreg <= 1'b1;
		repeat (8) @(posedge clock);
		ldo_unreg <= 1'b0;
		wait_run(n);
		chk("ldo rst", rst_seen, 1);
		rdc("cause", ADDR_CAUSE, 32'h35, RESP_OKAY);
		wr(ADDR_WDLOAD, 32'd30, RESP_OKAY);
		wr(ADDR_WDCTL, 32'h3, RESP_OKAY);
		n = 0;
		while (watchdog_irq !== 1'b1 && n < 2000) begin
			@(posedge clock);
			n++;
		end
		tmo(n);
		chk("wd first", sys_rst_n, 1);
		wait_run(n);
		wr(ADDR_WDCTL, 32'h0, RESP_OKAY);
		rdc("cause", ADDR_CAUSE, 32'h3d, RESP_OKAY);
		chk("boots", boots, 6);
		chk("fetch order", order_err, 0);
		$display("test internal done");
		finish_test();
	end
endmodule : system_reset_controller_test
